// *** hdl/jlsm_consts.svh ***
// constants for the lane sample mapper
`ifndef JLSM_CONSTS_SVH
`define JLSM_CONSTS_SVH

// ----------------------------------------
// frame geometry
// ----------------------------------------
`define JLSM_LANES 8
`define JLSM_CHANS 4
`define JLSM_SMPS 8
`define JLSM_SMP_BITS 9
`define JLSM_LANE_BITS 40

// ----------------------------------------
// octets per lane per frame, by mode
// ----------------------------------------
`define JLSM_OCT_ONE 3'h1
`define JLSM_OCT_TWO 3'h2
`define JLSM_OCT_THREE 3'h3
`define JLSM_OCT_FIVE 3'h5

// ----------------------------------------
// reset values
// ----------------------------------------
`define JLSM_RST_OCT 3'h0
`define JLSM_RST_EN 8'h00

`endif

// *** hdl/jlsm_pkg.sv ***
// types for the lane sample mapper
package jlsm_pkg;

  // ----------------------------------------
  // link packing modes handled here
  // ----------------------------------------
  typedef enum logic [3:0] {
    JLSM_M2 = 4'h2,
    JLSM_M3 = 4'h3,
    JLSM_M4 = 4'h4,
    JLSM_M5 = 4'h5,
    JLSM_M6 = 4'h6,
    JLSM_M7 = 4'h7,
    JLSM_M8 = 4'h8,
    JLSM_M9 = 4'h9,
    JLSM_M10 = 4'hA
  } jlsm_mode_t;

  // ----------------------------------------
  // part variants
  // ----------------------------------------
  typedef enum logic [1:0] {
    JLSM_QUAD = 2'h0,
    JLSM_DUAL = 2'h1,
    JLSM_SINGLE = 2'h2
  } jlsm_variant_t;

  // samples: [channel A..D][sample 0..7][bit 8..0]
  typedef logic [3:0][7:0][8:0] jlsm_smp_t;

  // one frame of converter samples
  typedef struct packed {
    logic valid;
    jlsm_smp_t smp;
  } jlsm_frame_t;

  // one frame of lane octets, octet 0 in bits 39:32
  typedef struct packed {
    logic valid;
    logic [7:0] lane_en;
    logic [2:0] octets;
    logic [7:0][39:0] data;
  } jlsm_lanes_t;

endpackage

// *** hdl/jlsm_mapper.sv ***
// lane sample mapper: packs channel samples into lane frame octets
// Notes on behaviour
// - mode 2: lane k carries channel k octet
// - mode 3: five octets, four 10-bit padded samples
// - mode 4 lane 0: A, B top bits
// - mode 5: two octets, A then B/zero
// - mode 6: 12-bit samples split over three lanes
// - mode 7: lane k carries channel k octet
// - mode 8: three octets, two 12-bit samples
// - mode 9: two lanes per channel, even/odd samples
// - mode 10: two lanes per channel, five octets, even/odd samples
`timescale 1ns/1ns
`include "jlsm_consts.svh"

module jlsm_mapper (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // configuration
  input wire logic [3:0] link_packing_mode,
  input wire logic [1:0] part_variant,
  // sample frame in
  input wire jlsm_pkg::jlsm_frame_t frame_in,
  // lane frame out
  output jlsm_pkg::jlsm_lanes_t lanes_out
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // eight msbs of a sample for 8-bit modes
  function automatic logic [7:0] hi8(input logic [8:0] s);
    return s[8:1];
  endfunction

  // sample plus one zero pad bit
  function automatic logic [9:0] p10(input logic [8:0] s);
    return {s, 1'h0};
  endfunction

  // sample plus three zero pad bits
  function automatic logic [11:0] p12(input logic [8:0] s);
    return {s, 3'h0};
  endfunction

  // number of lanes in use for mode and variant
  function automatic logic [3:0] lane_cnt(input logic [3:0] m, input logic [1:0] v);
    logic [3:0] nch;
    nch = (v == jlsm_pkg::JLSM_QUAD) ? 4'h4 : (v == jlsm_pkg::JLSM_DUAL) ? 4'h2 :
          (v == jlsm_pkg::JLSM_SINGLE) ? 4'h1 : 4'h0;
    case (m)
      jlsm_pkg::JLSM_M2, jlsm_pkg::JLSM_M3, jlsm_pkg::JLSM_M7, jlsm_pkg::JLSM_M8: return nch;
      jlsm_pkg::JLSM_M4: return (nch == 4'h4) ? 4'h3 : nch;
      jlsm_pkg::JLSM_M5: return (nch == 4'h4) ? 4'h2 : (nch == 4'h0) ? 4'h0 : 4'h1;
      jlsm_pkg::JLSM_M6: return (nch == 4'h0) ? 4'h0 : (nch == 4'h4) ? 4'h6 : nch + 4'h1;
      jlsm_pkg::JLSM_M9, jlsm_pkg::JLSM_M10: return {nch[2:0], 1'h0};
      default: return 4'h0;
    endcase
  endfunction

  // octets per lane per frame
  function automatic logic [2:0] oct_cnt(input logic [3:0] m);
    case (m)
      jlsm_pkg::JLSM_M2, jlsm_pkg::JLSM_M7, jlsm_pkg::JLSM_M9: return `JLSM_OCT_ONE;
      jlsm_pkg::JLSM_M4, jlsm_pkg::JLSM_M5, jlsm_pkg::JLSM_M6: return `JLSM_OCT_TWO;
      jlsm_pkg::JLSM_M8: return `JLSM_OCT_THREE;
      jlsm_pkg::JLSM_M3, jlsm_pkg::JLSM_M10: return `JLSM_OCT_FIVE;
      default: return `JLSM_RST_OCT;
    endcase
  endfunction

  // contents of one lane, octet 0 first, trailing octets zero
  function automatic logic [39:0] lane_map(input logic [3:0] m, input logic [1:0] v,
                                           input logic [2:0] ln, input jlsm_pkg::jlsm_smp_t s);
    logic [1:0] k;
    logic [1:0] ch;
    logic [2:0] sb;
    logic [1:0] cx;
    logic [1:0] cy;
    logic [2:0] pos;
    logic multi;
    logic quad;
    logic [39:0] w;
    k = ln[1:0];
    ch = ln[2:1];
    sb = {2'h0, ln[0]};
    cx = (ln >= 3'h3) ? 2'h2 : 2'h0;
    cy = (ln >= 3'h3) ? 2'h3 : 2'h1;
    pos = (ln >= 3'h3) ? ln - 3'h3 : ln;
    multi = (v == jlsm_pkg::JLSM_QUAD) || (v == jlsm_pkg::JLSM_DUAL);
    quad = (v == jlsm_pkg::JLSM_QUAD);
    w = '0;
    case (m)
      jlsm_pkg::JLSM_M2, jlsm_pkg::JLSM_M7: begin
        w = {hi8(s[k][0]), 32'h0};
      end
      jlsm_pkg::JLSM_M3: begin
        w = {p10(s[k][0]), p10(s[k][1]), p10(s[k][2]), p10(s[k][3])};
      end
      jlsm_pkg::JLSM_M4: begin
        if (ln == 3'h0) begin
          w = {s[0][0], 3'h0, multi ? s[1][0][8:5] : 4'h0, 24'h0};
        end else if (ln == 3'h1) begin
          w = {s[1][0][4:0], 3'h0, quad ? hi8(s[2][0]) : 8'h00, 24'h0};
        end else begin
          w = {s[2][0][0], 3'h0, s[3][0], 3'h0, 24'h0};
        end
      end
      jlsm_pkg::JLSM_M5: begin
        if (ln == 3'h0) begin
          w = {hi8(s[0][0]), (v == jlsm_pkg::JLSM_DUAL) ? hi8(s[1][0]) : 8'h00, 24'h0};
        end else begin
          w = {hi8(s[2][0]), hi8(s[3][0]), 24'h0};
        end
      end
      jlsm_pkg::JLSM_M6: begin
        // groups of three lanes: A,B on 0-2 and C,D on 3-5
        if (pos == 3'h0) begin
          w = {s[cx][0], 3'h0, s[cx][1][8:5], 24'h0};
        end else if (pos == 3'h1) begin
          w = {s[cx][1][4:0], 3'h0, multi ? s[cy][0][8:1] : 8'h00, 24'h0};
        end else begin
          w = {s[cy][0][0], 3'h0, s[cy][1], 3'h0, 24'h0};
        end
      end
      jlsm_pkg::JLSM_M8: begin
        w = {p12(s[k][0]), p12(s[k][1]), 16'h0};
      end
      jlsm_pkg::JLSM_M9: begin
        w = {hi8(s[ch][sb]), 32'h0};
      end
      jlsm_pkg::JLSM_M10: begin
        w = {p10(s[ch][sb]), p10(s[ch][sb + 3'h2]), p10(s[ch][sb + 3'h4]), p10(s[ch][sb + 3'h6])};
      end
      default: begin
        w = '0;
      end
    endcase
    return w;
  endfunction

  // ----------------------------------------
  // combinational mapping
  // ----------------------------------------
  // lanes beyond the count stay idle at zero
  wire logic [3:0] used_lanes;
  wire logic [2:0] frame_octets;
  wire logic frame_ok;
  wire logic [7:0][39:0] lane_nxt;
  wire logic [7:0] en_nxt;

  assign used_lanes = lane_cnt(link_packing_mode, part_variant);
  assign frame_octets = oct_cnt(link_packing_mode);
  assign frame_ok = frame_in.valid && (used_lanes != 4'h0);

  genvar gi;
  generate
    for (gi = 0; gi < `JLSM_LANES; gi++) begin : g_lane
      assign en_nxt[gi] = frame_ok && (4'(gi) < used_lanes);
      assign lane_nxt[gi] = en_nxt[gi] ? lane_map(link_packing_mode, part_variant, 3'(gi), frame_in.smp) : '0;
    end
  endgenerate

  // ----------------------------------------
  // output register
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lanes_out <= '0;
    end else begin
      lanes_out.valid <= frame_ok;
      lanes_out.lane_en <= en_nxt;
      lanes_out.octets <= frame_ok ? frame_octets : `JLSM_RST_OCT;
      lanes_out.data <= lane_nxt;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  wire logic is_quad;
  wire logic is_single;
  assign is_quad = (part_variant == jlsm_pkg::JLSM_QUAD);
  assign is_single = (part_variant == jlsm_pkg::JLSM_SINGLE);

  property p_mode2;
    @(posedge clk) disable iff (!arst_n)
    (frame_in.valid && link_packing_mode == jlsm_pkg::JLSM_M2 && is_quad) |=>
      (lanes_out.data[3] == {$past(frame_in.smp[3][0][8:1]), 32'h0} && lanes_out.octets == 3'h1);
  endproperty
  a_mode2: assert property (p_mode2) else $error("mode 2 lane 3 wrong");

  property p_mode3;
    @(posedge clk) disable iff (!arst_n)
    (frame_in.valid && link_packing_mode == jlsm_pkg::JLSM_M3 && !is_single && part_variant != 2'h3) |=>
      (lanes_out.data[1][39:30] == {$past(frame_in.smp[1][0]), 1'h0} &&
       lanes_out.data[1][9:0] == {$past(frame_in.smp[1][3]), 1'h0});
  endproperty
  a_mode3: assert property (p_mode3) else $error("mode 3 lane 1 wrong");

  property p_mode4_l0;
    @(posedge clk) disable iff (!arst_n)
    (frame_in.valid && link_packing_mode == jlsm_pkg::JLSM_M4 && is_single) |=>
      (lanes_out.data[0][39:24] == {$past(frame_in.smp[0][0]), 7'h00} && lanes_out.lane_en == 8'h01);
  endproperty
  a_mode4_l0: assert property (p_mode4_l0) else $error("mode 4 single lane 0 wrong");

  property p_mode4_l2;
    @(posedge clk) disable iff (!arst_n)
    (frame_in.valid && link_packing_mode == jlsm_pkg::JLSM_M4 && is_quad) |=>
      (lanes_out.data[2][39:24] == {$past(frame_in.smp[2][0][0]), 3'h0, $past(frame_in.smp[3][0]), 3'h0});
  endproperty
  a_mode4_l2: assert property (p_mode4_l2) else $error("mode 4 lane 2 wrong");

  property p_mode5;
    @(posedge clk) disable iff (!arst_n)
    (frame_in.valid && link_packing_mode == jlsm_pkg::JLSM_M5 && is_quad) |=>
      (lanes_out.data[0][31:24] == 8'h00 && lanes_out.data[1][39:32] == $past(frame_in.smp[2][0][8:1]));
  endproperty
  a_mode5: assert property (p_mode5) else $error("mode 5 quad packing wrong");

  property p_mode6;
    @(posedge clk) disable iff (!arst_n)
    (frame_in.valid && link_packing_mode == jlsm_pkg::JLSM_M6 && is_quad) |=>
      (lanes_out.data[3][39:24] == {$past(frame_in.smp[2][0]), 3'h0, $past(frame_in.smp[2][1][8:5])} &&
       lanes_out.lane_en == 8'h3F);
  endproperty
  a_mode6: assert property (p_mode6) else $error("mode 6 lane 3 wrong");

  property p_mode6_l1;
    @(posedge clk) disable iff (!arst_n)
    (frame_in.valid && link_packing_mode == jlsm_pkg::JLSM_M6 && is_single) |=>
      (lanes_out.data[1][39:24] == {$past(frame_in.smp[0][1][4:0]), 11'h000} && lanes_out.lane_en == 8'h03);
  endproperty
  a_mode6_l1: assert property (p_mode6_l1) else $error("mode 6 single lane 1 wrong");

  property p_mode8;
    @(posedge clk) disable iff (!arst_n)
    (frame_in.valid && link_packing_mode == jlsm_pkg::JLSM_M8 && is_quad) |=>
      (lanes_out.data[2][27:16] == {$past(frame_in.smp[2][1]), 3'h0} && lanes_out.octets == 3'h3);
  endproperty
  a_mode8: assert property (p_mode8) else $error("mode 8 lane 2 wrong");

  property p_mode9;
    @(posedge clk) disable iff (!arst_n)
    (frame_in.valid && link_packing_mode == jlsm_pkg::JLSM_M9 && is_quad) |=>
      (lanes_out.data[7][39:32] == $past(frame_in.smp[3][1][8:1]) && lanes_out.lane_en == 8'hFF);
  endproperty
  a_mode9: assert property (p_mode9) else $error("mode 9 lane 7 wrong");

  property p_mode10;
    @(posedge clk) disable iff (!arst_n)
    (frame_in.valid && link_packing_mode == jlsm_pkg::JLSM_M10 && is_single) |=>
      (lanes_out.data[1][9:0] == {$past(frame_in.smp[0][7]), 1'h0} && lanes_out.lane_en == 8'h03);
  endproperty
  a_mode10: assert property (p_mode10) else $error("mode 10 lane 1 wrong");

  property p_mode7;
    @(posedge clk) disable iff (!arst_n)
    (frame_in.valid && link_packing_mode == jlsm_pkg::JLSM_M7 && part_variant == jlsm_pkg::JLSM_DUAL) |=>
      (lanes_out.data[1][39:32] == $past(frame_in.smp[1][0][8:1]) && lanes_out.lane_en == 8'h03);
  endproperty
  a_mode7: assert property (p_mode7) else $error("mode 7 dual lanes wrong");

  property p_idle;
    @(posedge clk) disable iff (!arst_n)
    (!frame_in.valid || used_lanes == 4'h0) |=>
      (!lanes_out.valid && lanes_out.lane_en == 8'h00 && lanes_out.data == '0);
  endproperty
  a_idle: assert property (p_idle) else $error("idle frame not zero");

endmodule

// *** verif/jlsm_rx_model.sv ***
// receiver model that recovers samples from lane frames
`timescale 1ns/1ns

module jlsm_rx_model (
  // lane frame in
  input wire jlsm_pkg::jlsm_lanes_t lanes,
  input wire logic [3:0] mode,
  // recovered samples
  output logic [8:0] a0,
  output logic [8:0] b0
);
  logic eight;

  // ----------------------------------------
  // inverse mapping
  // ----------------------------------------
  // 8-bit modes carry bits 8:1, bit 0 comes back as zero
  assign eight = mode inside {4'h2, 4'h5, 4'h7, 4'h9};
  // channel A sample 0 heads lane 0 in every mode
  assign a0 = lanes.data[0][39:31] & {8'hFF, !eight};
  // channel B sample 0 is split over two lanes in modes 4 and 6
  assign b0 = (mode == 4'h4) ? {lanes.data[0][27:24], lanes.data[1][39:35]} :
    (mode == 4'h6) ? {lanes.data[1][31:24], lanes.data[2][39]} : 9'h000;
endmodule

// *** verif/jesd_lane_sample_mapper_bench.sv ***
// self-checking bench for the lane sample mapper
`timescale 1ns/1ns

module jesd_lane_sample_mapper_bench;
  logic clk;
  logic arst_n;
  logic [3:0] mode;
  logic [1:0] variant;
  jlsm_pkg::jlsm_frame_t fin;
  jlsm_pkg::jlsm_lanes_t lout;
  logic [8:0] a0;
  logic [8:0] b0;
  int mismatches;
  int comparisons;

  // ----------------------------------------
  // design and receiver
  // ----------------------------------------
  jlsm_mapper i_jlsm_mapper (.clk(clk), .arst_n(arst_n), .link_packing_mode(mode),
    .part_variant(variant), .frame_in(fin), .lanes_out(lout));
  jlsm_rx_model i_jlsm_rx_model (.lanes(lout), .mode(mode), .a0(a0), .b0(b0));

  // ----------------------------------------
  // reference mapping
  // ----------------------------------------
  function automatic int nlanes(input logic [3:0] m, input int nc);
    case (m)
      4'h4: return (nc == 4) ? 3 : nc;
      4'h5: return (nc == 4) ? 2 : 1;
      4'h6: return (nc == 4) ? 6 : nc + 1;
      4'h9, 4'hA: return 2 * nc;
      default: return nc;
    endcase
  endfunction

  function automatic logic [2:0] noct(input logic [3:0] m);
    case (m)
      4'h3, 4'hA: return 3'h5;
      4'h4, 4'h5, 4'h6: return 3'h2;
      4'h8: return 3'h3;
      default: return 3'h1;
    endcase
  endfunction

  function automatic logic [39:0] ref_lane(input logic [3:0] m, input int nc, input int l,
                                           input jlsm_pkg::jlsm_smp_t s);
    logic [39:0] r;
    int c;
    int k;
    r = 40'h0;
    c = (l / 3) * 2;
    k = l % 2;
    if (l < nlanes(m, nc)) begin
      case (m)
        4'h2, 4'h7: r[39:32] = s[l][0][8:1];
        4'h3: r = {s[l][0], 1'b0, s[l][1], 1'b0, s[l][2], 1'b0, s[l][3], 1'b0};
        4'h8: r[39:16] = {s[l][0], 3'h0, s[l][1], 3'h0};
        4'h9: r[39:32] = s[l/2][k][8:1];
        4'hA: r = {s[l/2][k], 1'b0, s[l/2][k+2], 1'b0, s[l/2][k+4], 1'b0, s[l/2][k+6], 1'b0};
        4'h4: r[39:24] = (l == 0) ? {s[0][0], 3'h0, (nc > 1) ? s[1][0][8:5] : 4'h0} :
          (l == 1) ? {s[1][0][4:0], 3'h0, (nc > 3) ? s[2][0][8:1] : 8'h00} :
          {s[2][0][0], 3'h0, s[3][0], 3'h0};
        4'h5: r[39:24] = (l == 0) ? {s[0][0][8:1], (nc == 2) ? s[1][0][8:1] : 8'h00} :
          {s[2][0][8:1], s[3][0][8:1]};
        default: r[39:24] = (l % 3 == 0) ? {s[c][0], 3'h0, s[c][1][8:5]} :
          (l % 3 == 1) ? {s[c][1][4:0], 3'h0, (nc > 1) ? s[c+1][0][8:1] : 8'h00} :
          {s[c+1][0][0], 3'h0, s[c+1][1], 3'h0};
      endcase
    end
    return r;
  endfunction

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one frame in, whole lane frame checked one cycle later
  task automatic run(input logic [3:0] m, input logic [1:0] v, input jlsm_pkg::jlsm_smp_t s);
    int nc;
    logic [7:0] en;
    nc = (v == 2'h0) ? 4 : (v == 2'h1) ? 2 : 1;
    en = 8'h00;
    @(posedge clk);
    mode <= m;
    variant <= v;
    fin <= {1'b1, s};
    @(posedge clk);
    #1;
    chk(lout.valid, 1'b1);
    chk(lout.octets, noct(m));
    for (int l = 0; l < 8; l++) begin
      en[l] = (l < nlanes(m, nc));
      chk(lout.data[l], ref_lane(m, nc, l, s));
    end
    chk(lout.lane_en, en);
    chk(a0, {s[0][0][8:1], (m inside {4'h2, 4'h5, 4'h7, 4'h9}) ? 1'b0 : s[0][0][0]});
    if ((m == 4'h4 || m == 4'h6) && nc > 1) begin
      chk(b0, s[1][0]);
    end
  endtask

  // refused frame: all outputs zero next cycle
  task automatic zero(input logic [3:0] m, input logic [1:0] v, input logic val);
    @(posedge clk);
    mode <= m;
    variant <= v;
    fin.valid <= val;
    @(posedge clk);
    #1;
    chk(lout.valid, 1'b0);
    chk(lout.lane_en, 8'h00);
    chk(lout.octets, 3'h0);
    chk(|lout.data, 1'b0);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // every mode and variant, three sample patterns, back to back
  task automatic t_modes();
    jlsm_pkg::jlsm_smp_t s;
    for (int p = 0; p < 3; p++) begin
      for (int c = 0; c < 4; c++) begin
        for (int i = 0; i < 8; i++) begin
          s[c][i] = (p == 0) ? 9'h1FF : (p == 1) ? 9'(9'h155 ^ (c * 8 + i)) : 9'(9'h0AA + c * 37 + i * 11);
        end
      end
      for (int m = 2; m <= 10; m++) begin
        for (int v = 0; v < 3; v++) begin
          run(4'(m), 2'(v), s);
        end
      end
    end
    $display("test modes done");
  endtask

  // illegal codes and idle input give no frame
  task automatic t_refuse();
    zero(4'h0, 2'h0, 1'b1);
    zero(4'h1, 2'h1, 1'b1);
    zero(4'hB, 2'h0, 1'b1);
    zero(4'hF, 2'h2, 1'b1);
    zero(4'h2, 2'h3, 1'b1);
    zero(4'h2, 2'h0, 1'b0);
    $display("test refuse done");
  endtask

  // reset in mid-run clears outputs, frame at first edge after release
  task automatic t_reset();
    @(posedge clk);
    mode <= 4'h3;
    variant <= 2'h0;
    fin.valid <= 1'h1;
    @(posedge clk);
    #1;
    chk(lout.valid, 1'h1);
    // reset falls at this edge and clears the frame just taken
    @(posedge clk);
    arst_n <= 1'h0;
    #1;
    chk(lout.valid, 1'h0);
    chk(lout.octets, 3'h0);
    // release edge: design still in reset here
    @(posedge clk);
    arst_n <= 1'h1;
    #1;
    chk(lout.valid, 1'h0);
    chk(|lout.data, 1'h0);
    // first edge after release takes the frame
    @(posedge clk);
    fin.valid <= 1'h0;
    #1;
    chk(lout.valid, 1'h1);
    chk(lout.octets, 3'h5);
    @(posedge clk);
    #1;
    chk(lout.valid, 1'h0);
    $display("test reset done");
  endtask

  // ----------------------------------------
  // clock, main sequence, watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    arst_n = 1'b0;
    mode = 4'h2;
    variant = 2'h0;
    fin = '0;
    mismatches = 0;
    comparisons = 0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    t_modes();
    t_refuse();
    t_reset();
    summarize();
  end

  initial begin
    #100000;
    mismatches++;
    summarize();
  end
endmodule
